// ### logic/idc_device.sv
// guard-locking interlock: fault supervision, indicators, diagnostics
//
// Summary of operation
// R1 - green lit whenever powered
// R2 - yellow blinks when actuator near range edge
// R3 - warning faults blink one to four, 30 min
// R4 - error faults shut down at once, five/six/steady
// R5 - internal failure drops both outputs immediately
// R6 - conventional: clear after cause gone, guard cycled
// R7 - restart needs lock held continuously
// R8 - warning keeps outputs, forced off after 30 min
// R9 - diag output high only closed, locked, fault-free
// R10 - chain holds at most 31 interlocks
// R11 - each member trades request and response continuously
// R12 - link loss holds present switching state
// R13 - serial: clear on cause gone and reset fall
// R14 - output failures stay latched until next release
// R15 - request bit0 solenoid, bit7 failure reset
// R16 - response byte status bit layout
// R17 - diagnostic byte fault bit layout
// R18 - all status bits active high
// R19 - closed, unlocked: yellow blinks, outputs low
// R20 - closed and locked: yellow steady, outputs high
// R21 - red groups repeat with a separating pause
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module idc_device #(
	parameter logic [idc_pkg::NODE_W-1:0] NODE_ID = 5'h00,
	parameter longint WARN_CYC = idc_pkg::WARN_DELAY_CYC,
	parameter int BLINK_CYC = idc_pkg::BLINK_HALF_CYC,
	parameter int COMM_CYC = idc_pkg::COMM_TIMEOUT_CYC
) (
	input logic sys_clk_in,
	input logic reset_in,
	input logic serial_variant_in,
	input logic guard_closed_in,
	input logic actuator_detected_in,
	input logic actuator_near_edge_in,
	input logic locked_in,
	input logic safety_input_a_in,
	input logic safety_input_b_in,
	input logic solenoid_cmd_in,
	input logic out_a_fault_in,
	input logic out_b_fault_in,
	input logic cross_wire_in,
	input logic over_temp_in,
	input logic wrong_actuator_in,
	input logic bad_combination_in,
	input logic internal_fail_in,
	input logic undervoltage_in,
	idc_link_if.dev link,
	output logic led_green_out,
	output logic led_yellow_out,
	output logic led_red_out,
	output logic safety_output_a_out,
	output logic safety_output_b_out,
	output logic diag_out,
	output logic solenoid_out
);
	import idc_pkg::*;

	localparam int BLINK_W = $clog2(BLINK_CYC + 1);
	localparam int COMM_W = $clog2(COMM_CYC + 1);
	localparam logic [WARN_CNT_W-1:0] WARN_LAST =
		WARN_CNT_W'(WARN_CYC - 1);
	localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYC - 1);
	localparam logic [COMM_W-1:0] COMM_LAST = COMM_W'(COMM_CYC);

	// ==========================================================
	// fault classification
	logic warn_cause;
	logic err_cause;
	logic cause_gone;
	logic [2:0] code_now;
	logic [5:0] cause_bits;

	assign cause_bits = {internal_fail_in, wrong_actuator_in | bad_combination_in,
		over_temp_in, cross_wire_in | (out_a_fault_in & out_b_fault_in),
		out_b_fault_in, out_a_fault_in}; // [R17]
	assign warn_cause = out_a_fault_in | out_b_fault_in | cross_wire_in |
		over_temp_in;
	assign err_cause = wrong_actuator_in | bad_combination_in |
		internal_fail_in;
	assign cause_gone = ~(warn_cause | err_cause);

	// highest severity wins the blink code
	always_comb begin
		if (internal_fail_in) begin
			code_now = CODE_INTERNAL; // [R4]
		end else if (bad_combination_in) begin
			code_now = CODE_COMBINATION; // [R4]
		end else if (wrong_actuator_in) begin
			code_now = CODE_WRONG_ACT; // [R4]
		end else if (cross_wire_in | (out_a_fault_in & out_b_fault_in)) begin
			code_now = CODE_CROSS; // [R3]
		end else if (out_a_fault_in) begin
			code_now = CODE_OUT_A; // [R3]
		end else if (out_b_fault_in) begin
			code_now = CODE_OUT_B; // [R3]
		end else if (over_temp_in) begin
			code_now = CODE_TEMP; // [R3]
		end else begin
			code_now = CODE_NONE;
		end
	end

	// ==========================================================
	// link: request capture, watchdog, response
	logic [7:0] req_q, req_d;
	logic rst_prev_q, rst_prev_d;
	logic [COMM_W-1:0] comm_cnt_q, comm_cnt_d;
	logic comm_err_q, comm_err_d;
	logic rsp_valid_q, rsp_valid_d;
	logic [7:0] rsp_data_q, rsp_data_d;
	logic [7:0] rsp_diag_q, rsp_diag_d;
	logic own_frame;
	logic rst_fall;
	logic [7:0] status_byte;
	logic [7:0] diag_byte;
	idc_fault_state_t state_q, state_d;
	logic [2:0] code_q, code_d;
	logic [5:0] fdiag_q, fdiag_d;
	logic out_en_q, out_en_d;

	assign own_frame = link.req_valid & (link.req_node == NODE_ID); // [R10]
	assign rst_fall = rst_prev_q & ~req_q[REQ_RESET]; // [R13]

	always_comb begin
		status_byte = 8'h00;
		status_byte[RSP_OUT_EN] = out_en_q; // [R16]
		status_byte[RSP_ACT] = actuator_detected_in; // [R16]
		status_byte[RSP_LOCKED] = actuator_detected_in & locked_in; // [R16]
		status_byte[RSP_INPUTS] = safety_input_a_in & safety_input_b_in;
		status_byte[RSP_GUARD] = guard_closed_in; // [R16]
		status_byte[RSP_WARN] = (state_q == ST_WARN); // [R16] [R18]
		status_byte[RSP_FAIL] = (state_q == ST_FAIL); // [R16] [R18]
		diag_byte = {undervoltage_in, comm_err_q,
			(state_q == ST_FAIL) ? fdiag_q : cause_bits}; // [R17]
	end

	always_comb begin
		req_d = req_q;
		rst_prev_d = req_q[REQ_RESET];
		comm_cnt_d = comm_cnt_q;
		comm_err_d = comm_err_q;
		rsp_valid_d = 1'b0;
		rsp_data_d = rsp_data_q;
		rsp_diag_d = rsp_diag_q;
		if (own_frame) begin
			req_d = link.req_data; // [R11] [R15]
			comm_cnt_d = '0;
			comm_err_d = 1'b0;
			rsp_valid_d = 1'b1; // [R11]
			rsp_data_d = status_byte;
			rsp_diag_d = diag_byte;
		end else if (comm_cnt_q == COMM_LAST) begin
			comm_err_d = 1'b1; // [R12]
		end else begin
			comm_cnt_d = comm_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			req_q <= 8'h00;
			rst_prev_q <= 1'b0;
			comm_cnt_q <= '0;
			comm_err_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 8'h00;
			rsp_diag_q <= 8'h00;
		end else begin
			req_q <= req_d;
			rst_prev_q <= rst_prev_d;
			comm_cnt_q <= comm_cnt_d;
			comm_err_q <= comm_err_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
			rsp_diag_q <= rsp_diag_d;
		end
	end

	assign link.rsp_valid = rsp_valid_q;
	assign link.rsp_node = NODE_ID;
	assign link.rsp_data = rsp_data_q;
	assign link.rsp_diag = rsp_diag_q;

	// ==========================================================
	// fault state machine
	logic [WARN_CNT_W-1:0] warn_cnt_q, warn_cnt_d;
	logic opened_q, opened_d;
	logic out_fault;
	logic clear_ok;

	assign out_fault = (code_q == CODE_OUT_A) | (code_q == CODE_OUT_B) |
		(code_q == CODE_CROSS);

	always_comb begin
		if (serial_variant_in) begin
			if (out_fault) begin
				clear_ok = cause_gone & ~guard_closed_in; // [R14]
			end else begin
				clear_ok = cause_gone & (rst_fall | ~guard_closed_in); // [R13]
			end
		end else begin
			clear_ok = cause_gone & opened_q & guard_closed_in; // [R6]
		end
	end

	always_comb begin
		state_d = state_q;
		code_d = code_q;
		fdiag_d = fdiag_q;
		warn_cnt_d = warn_cnt_q;
		opened_d = opened_q;
		case (state_q)
			ST_OK: begin
				warn_cnt_d = '0;
				if (err_cause) begin
					state_d = ST_FAIL; // [R4] [R5]
					code_d = code_now;
					fdiag_d = cause_bits;
					opened_d = 1'b0;
				end else if (warn_cause) begin
					state_d = ST_WARN; // [R8]
				end
			end
			ST_WARN: begin
				if (err_cause || warn_cnt_q == WARN_LAST) begin
					state_d = ST_FAIL; // [R3] [R8]
					code_d = code_now;
					fdiag_d = cause_bits;
					opened_d = 1'b0;
				end else if (!warn_cause) begin
					state_d = ST_OK; // [R8]
				end else begin
					warn_cnt_d = warn_cnt_q + 1'b1;
				end
			end
			ST_FAIL: begin
				warn_cnt_d = '0;
				if (!guard_closed_in) begin
					opened_d = 1'b1;
				end
				if (clear_ok) begin
					state_d = ST_OK;
					code_d = CODE_NONE;
					fdiag_d = 6'h00;
				end
			end
			default: begin
				state_d = ST_FAIL;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			state_q <= ST_OK;
			code_q <= CODE_NONE;
			fdiag_q <= 6'h00;
			warn_cnt_q <= '0;
			opened_q <= 1'b0;
		end else begin
			state_q <= state_d;
			code_q <= code_d;
			fdiag_q <= fdiag_d;
			warn_cnt_q <= warn_cnt_d;
			opened_q <= opened_d;
		end
	end

	// ==========================================================
	// blink timebase: slots of two half periods, then a pause
	logic [BLINK_W-1:0] half_cnt_q, half_cnt_d;
	logic half_q, half_d;
	logic [3:0] slot_q, slot_d;
	logic [2:0] shown_code;

	assign shown_code = (state_q == ST_FAIL) ? code_q :
		((state_q == ST_WARN) ? code_now : CODE_NONE);

	always_comb begin
		half_cnt_d = half_cnt_q + 1'b1;
		half_d = half_q;
		slot_d = slot_q;
		if (half_cnt_q == BLINK_LAST) begin
			half_cnt_d = '0;
			half_d = ~half_q;
			if (half_q) begin
				if (slot_q >= {1'b0, shown_code} + BLINK_GAP_SLOTS - 4'h1) begin
					slot_d = 4'h0; // [R21]
				end else begin
					slot_d = slot_q + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			half_cnt_q <= '0;
			half_q <= 1'b0;
			slot_q <= 4'h0;
		end else begin
			half_cnt_q <= half_cnt_d;
			half_q <= half_d;
			slot_q <= slot_d;
		end
	end

	// ==========================================================
	// outputs
	logic yellow_d, red_d, diag_d, sol_d;

	always_comb begin
		out_en_d = guard_closed_in & actuator_detected_in & locked_in &
			safety_input_a_in & safety_input_b_in &
			(state_q != ST_FAIL) & ~err_cause; // [R5] [R7] [R20]
		if (state_q == ST_FAIL) begin
			yellow_d = 1'b0;
		end else if (actuator_near_edge_in ||
			(actuator_detected_in && !locked_in)) begin
			yellow_d = ~half_q; // [R2] [R19]
		end else begin
			yellow_d = actuator_detected_in & locked_in; // [R20]
		end
		if (shown_code == CODE_INTERNAL) begin
			red_d = 1'b1; // [R4]
		end else begin
			red_d = (slot_q < {1'b0, shown_code}) & ~half_q; // [R3] [R21]
		end
		diag_d = guard_closed_in & locked_in & (state_q == ST_OK); // [R9]
		sol_d = serial_variant_in ? req_q[REQ_SOLENOID] : solenoid_cmd_in;
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			led_green_out <= 1'b1; // [R1]
			led_yellow_out <= 1'b0;
			led_red_out <= 1'b0;
			out_en_q <= 1'b0;
			diag_out <= 1'b0;
			solenoid_out <= 1'b0;
		end else begin
			led_green_out <= 1'b1; // [R1]
			led_yellow_out <= yellow_d;
			led_red_out <= red_d;
			out_en_q <= out_en_d;
			diag_out <= diag_d;
			solenoid_out <= sol_d; // [R12]
		end
	end

	assign safety_output_a_out = out_en_q;
	assign safety_output_b_out = out_en_q;
endmodule : idc_device

// ### logic/idc_gateway.sv
// gateway end: APB registers and continuous polling of the chain
`timescale 1ns/1ps
module idc_gateway #(
	parameter int ANSWER_CYC = idc_pkg::GW_ANSWER_CYC
) (
	input logic sys_clk_in,
	input logic reset_in,
	input logic psel_in,
	input logic penable_in,
	input logic pwrite_in,
	input logic [11:0] paddr_in,
	input logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	idc_link_if.gw link
);
	import idc_pkg::*;

	localparam int ANS_W = $clog2(ANSWER_CYC + 1);

	logic [7:0] req_mem [MAX_NODES];
	logic [15:0] rsp_mem [MAX_NODES];
	logic [31:0] ctrl_q, ctrl_d;
	logic [30:0] miss_q, miss_d;
	logic [4:0] a_idx;
	logic a_req, a_rsp, a_ok;
	logic wr_en;
	logic [31:0] rd_d;
	logic rdy_d;
	logic err_d;
	logic [4:0] count;

	// ==========================================================
	// APB slave
	assign a_idx = paddr_in[6:2];
	assign a_req = (paddr_in[11:7] == GW_REQ_BASE[11:7]) &&
		(a_idx < 5'(MAX_NODES));
	assign a_rsp = (paddr_in[11:7] == GW_RSP_BASE[11:7]) &&
		(a_idx < 5'(MAX_NODES));
	assign a_ok = a_req | a_rsp | (paddr_in == GW_CTRL) |
		(paddr_in == GW_STAT);
	assign wr_en = psel_in & penable_in & pready_out & pwrite_in & a_ok;

	always_comb begin
		rdy_d = psel_in & ~penable_in;
		err_d = psel_in & ~penable_in & ~a_ok;
		rd_d = 32'h0000_0000;
		if (a_req) begin
			rd_d = {24'h00_0000, req_mem[a_idx]};
		end else if (a_rsp) begin
			rd_d = {16'h0000, rsp_mem[a_idx]};
		end else if (paddr_in == GW_CTRL) begin
			rd_d = ctrl_q;
		end else if (paddr_in == GW_STAT) begin
			rd_d = {1'b0, miss_q};
		end
		ctrl_d = ctrl_q;
		if (wr_en && paddr_in == GW_CTRL) begin
			ctrl_d = pwdata_in & 32'h0000_1F01;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			ctrl_q <= CTRL_RESET;
		end else begin
			pready_out <= rdy_d;
			pslverr_out <= err_d;
			prdata_out <= rd_d;
			ctrl_q <= ctrl_d;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (wr_en && a_req) begin
			req_mem[a_idx] <= pwdata_in[7:0]; // [R15]
		end
	end

	// ==========================================================
	// poller: one request per node, wait for answer or timeout
	idc_gw_state_t gs_q, gs_d;
	logic [4:0] node_q, node_d;
	logic [ANS_W-1:0] wait_q, wait_d;
	logic got;

	assign count = (ctrl_q[CTRL_CNT_LSB +: 5] == 5'h00) ? 5'h01 :
		ctrl_q[CTRL_CNT_LSB +: 5]; // [R10]
	assign got = link.rsp_valid & (link.rsp_node == node_q);

	always_comb begin
		gs_d = gs_q;
		node_d = node_q;
		wait_d = wait_q;
		miss_d = miss_q;
		case (gs_q)
			GS_IDLE: begin
				node_d = 5'h00;
				if (ctrl_q[CTRL_EN]) begin
					gs_d = GS_SEND;
				end
			end
			GS_SEND: begin
				wait_d = '0;
				gs_d = GS_WAIT;
			end
			GS_WAIT: begin
				wait_d = wait_q + 1'b1;
				if (got || wait_q == ANS_W'(ANSWER_CYC)) begin
					miss_d[node_q] = ~got;
					node_d = (node_q + 5'h01 >= count) ? 5'h00 :
						node_q + 5'h01; // [R11]
					gs_d = ctrl_q[CTRL_EN] ? GS_SEND : GS_IDLE;
				end
			end
			default: begin
				gs_d = GS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			gs_q <= GS_IDLE;
			node_q <= 5'h00;
			wait_q <= '0;
			miss_q <= 31'h0000_0000;
			link.req_valid <= 1'b0;
			link.req_node <= 5'h00;
			link.req_data <= 8'h00;
		end else begin
			gs_q <= gs_d;
			node_q <= node_d;
			wait_q <= wait_d;
			miss_q <= miss_d;
			link.req_valid <= (gs_q == GS_SEND);
			link.req_node <= node_q;
			link.req_data <= req_mem[node_q]; // [R15]
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (gs_q == GS_WAIT && got) begin
			rsp_mem[node_q] <= {link.rsp_diag, link.rsp_data}; // [R11]
		end
	end
endmodule : idc_gateway

// ### shared/idc_link_if.sv
// request and response link between gateway and chained interlocks
`timescale 1ns/1ps
interface idc_link_if;
	logic req_valid;
	logic [idc_pkg::NODE_W-1:0] req_node;
	logic [7:0] req_data;
	logic rsp_valid;
	logic [idc_pkg::NODE_W-1:0] rsp_node;
	logic [7:0] rsp_data;
	logic [7:0] rsp_diag;
	modport gw (
		output req_valid, req_node, req_data,
		input rsp_valid, rsp_node, rsp_data, rsp_diag
	);
	modport dev (
		input req_valid, req_node, req_data,
		output rsp_valid, rsp_node, rsp_data, rsp_diag
	);
endinterface : idc_link_if

// ### shared/idc_pkg.sv
// shared constants and types for the interlock diagnostic controller
package idc_pkg;
	// ==========================================================
	// clock and time
	localparam int CLK_HZ = 25_000_000;
	localparam longint WARN_DELAY_MIN = 30;
	localparam longint WARN_DELAY_CYC = WARN_DELAY_MIN * 60 * CLK_HZ;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam int COMM_TIMEOUT_MS = 100;
	localparam int COMM_TIMEOUT_CYC = COMM_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int GW_ANSWER_CYC = 16;
	localparam int WARN_CNT_W = 36;
	// ==========================================================
	// chain
	localparam int MAX_NODES = 31;
	localparam int NODE_W = 5;
	// ==========================================================
	// request byte bits
	localparam int REQ_SOLENOID = 0;
	localparam int REQ_RESET = 7;
	// response byte bits
	localparam int RSP_OUT_EN = 0;
	localparam int RSP_ACT = 1;
	localparam int RSP_LOCKED = 2;
	localparam int RSP_INPUTS = 4;
	localparam int RSP_GUARD = 5;
	localparam int RSP_WARN = 6;
	localparam int RSP_FAIL = 7;
	// diagnostic byte bits
	localparam int DG_OUT_A = 0;
	localparam int DG_OUT_B = 1;
	localparam int DG_CROSS = 2;
	localparam int DG_TEMP = 3;
	localparam int DG_WRONG_ACT = 4;
	localparam int DG_INTERNAL = 5;
	localparam int DG_COMM = 6;
	localparam int DG_UNDERVOLT = 7;
	// ==========================================================
	// red blink codes, 7 = steady red
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_OUT_A = 3'h1;
	localparam logic [2:0] CODE_OUT_B = 3'h2;
	localparam logic [2:0] CODE_CROSS = 3'h3;
	localparam logic [2:0] CODE_TEMP = 3'h4;
	localparam logic [2:0] CODE_WRONG_ACT = 3'h5;
	localparam logic [2:0] CODE_COMBINATION = 3'h6;
	localparam logic [2:0] CODE_INTERNAL = 3'h7;
	localparam logic [3:0] BLINK_GAP_SLOTS = 4'h3;
	// ==========================================================
	// gateway register map
	localparam logic [11:0] GW_REQ_BASE = 12'h000;
	localparam logic [11:0] GW_RSP_BASE = 12'h080;
	localparam logic [11:0] GW_CTRL = 12'h100;
	localparam logic [11:0] GW_STAT = 12'h104;
	localparam int CTRL_EN = 0;
	localparam int CTRL_CNT_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
	// ==========================================================
	typedef enum logic [2:0] {
		ST_OK = 3'b001,
		ST_WARN = 3'b010,
		ST_FAIL = 3'b100
	} idc_fault_state_t;
	typedef enum logic [2:0] {
		GS_IDLE = 3'b001,
		GS_SEND = 3'b010,
		GS_WAIT = 3'b100
	} idc_gw_state_t;
endpackage : idc_pkg

// ### tb/idc_monitor.sv
// concurrent checks on the gateway to interlock link
`timescale 1ns/1ps
module idc_monitor (
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic req_valid_in,
	input wire logic [idc_pkg::NODE_W-1:0] req_node_in,
	input wire logic [7:0] req_data_in,
	input wire logic rsp_valid_in,
	input wire logic [idc_pkg::NODE_W-1:0] rsp_node_in,
	input wire logic [7:0] rsp_data_in,
	input wire logic [7:0] rsp_diag_in
);
	import idc_pkg::*;
	localparam logic [4:0] OWN_NODE = 5'h00;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);
	// ==========================================================
	// link framing
	property p_rsp_answer;
		req_valid_in && req_node_in == OWN_NODE |=>
			rsp_valid_in && rsp_node_in == OWN_NODE;
	endproperty
	a_rsp_answer: assert property (p_rsp_answer)
		else $error("no answer");
	property p_rsp_cause;
		rsp_valid_in |-> $past(req_valid_in) &&
			$past(req_node_in) == rsp_node_in;
	endproperty
	a_rsp_cause: assert property (p_rsp_cause)
		else $error("stray answer");
	property p_req_spacing;
		req_valid_in |=> !req_valid_in [*2];
	endproperty
	a_req_spacing: assert property (p_req_spacing)
		else $error("req close");
	property p_rsp_pulse;
		rsp_valid_in |=> !rsp_valid_in;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse)
		else $error("rsp too long");
	property p_node_range;
		req_valid_in |-> req_node_in < MAX_NODES;
	endproperty
	a_node_range: assert property (p_node_range)
		else $error("bad node");
	// ==========================================================
	// response and diagnostic byte layout
	property p_spare_bit;
		rsp_valid_in |-> !rsp_data_in[3];
	endproperty
	a_spare_bit: assert property (p_spare_bit)
		else $error("bit3 set");
	property p_fail_excl;
		rsp_valid_in && rsp_data_in[RSP_FAIL] |-> !rsp_data_in[RSP_WARN];
	endproperty
	a_fail_excl: assert property (p_fail_excl)
		else $error("fail+warn");
	property p_lock_bit;
		rsp_valid_in && rsp_data_in[RSP_LOCKED] |-> rsp_data_in[RSP_ACT];
	endproperty
	a_lock_bit: assert property (p_lock_bit)
		else $error("lock w/o act");
	property p_fail_diag;
		rsp_valid_in && rsp_data_in[RSP_FAIL] |-> rsp_diag_in[5:0] != 6'h00;
	endproperty
	a_fail_diag: assert property (p_fail_diag)
		else $error("fail without cause");
	c_enabled: cover property (rsp_valid_in && rsp_data_in[RSP_OUT_EN]);
	c_warn: cover property (rsp_valid_in && rsp_data_in[RSP_WARN]);
	c_fail: cover property (rsp_valid_in && rsp_data_in[RSP_FAIL]);
	c_reset: cover property (req_valid_in && req_data_in[REQ_RESET]);
endmodule : idc_monitor

// ### tb/interlock_diagnostic_controller_tb.sv
// self-checking bench: one gateway polling one interlock
`timescale 1ns/1ps
module interlock_diagnostic_controller_tb;
	import idc_pkg::*;
	localparam int BLK = 4;
	logic clk, rst, psel, pen, pwr, perr, prdy, ser, grd, act, near, lck;
	logic ina, inb, scmd, led_g, led_y, led_r, sa, sb, dgo, sol, rerr;
	logic [11:0] paddr;
	logic [31:0] pwd, prd, rdat;
	logic [7:0] flt;
	logic [7:0] dexp [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h10, 8'h20};
	int mismatches = 0;
	int n_compared = 0;
	int n;
	idc_link_if lnk();
	idc_device #(.NODE_ID(5'h00), .WARN_CYC(200), .BLINK_CYC(BLK),
		.COMM_CYC(40)) i_idc_device (.sys_clk_in(clk), .reset_in(rst),
		.serial_variant_in(ser), .guard_closed_in(grd),
		.actuator_detected_in(act), .actuator_near_edge_in(near),
		.locked_in(lck), .safety_input_a_in(ina), .safety_input_b_in(inb),
		.solenoid_cmd_in(scmd), .out_a_fault_in(flt[0]),
		.out_b_fault_in(flt[1]), .cross_wire_in(flt[2]),
		.over_temp_in(flt[3]), .wrong_actuator_in(flt[4]),
		.bad_combination_in(flt[5]), .internal_fail_in(flt[6]),
		.undervoltage_in(flt[7]), .link(lnk), .led_green_out(led_g),
		.led_yellow_out(led_y), .led_red_out(led_r),
		.safety_output_a_out(sa), .safety_output_b_out(sb),
		.diag_out(dgo), .solenoid_out(sol));
	idc_gateway i_idc_gateway (.sys_clk_in(clk), .reset_in(rst),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(prdy), .pslverr_out(perr), .link(lnk));
	idc_monitor i_idc_monitor (.sys_clk_in(clk), .reset_in(rst),
		.req_valid_in(lnk.req_valid), .req_node_in(lnk.req_node),
		.req_data_in(lnk.req_data), .rsp_valid_in(lnk.rsp_valid),
		.rsp_node_in(lnk.rsp_node), .rsp_data_in(lnk.rsp_data),
		.rsp_diag_in(lnk.rsp_diag));
	// ==========================================================
	// helpers
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		@(posedge clk);
		while (prdy !== 1'b1 && k < 50) begin
			k++;
			@(posedge clk);
		end
		if (k >= 50) begin
			mismatches++;
			test_done();
		end
		rdat = prd;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat & m, e);
	endtask : rd
	// rising edges of red (sel 0) or yellow (sel 1) over k cycles
	task rises(input int sel, input int k, output int r);
		logic p;
		logic v;
		r = 0;
		p = sel ? led_y : led_r;
		repeat (k) begin
			@(posedge clk);
			v = sel ? led_y : led_r;
			if (v && !p) r++;
			p = v;
		end
	endtask : rises
	// ==========================================================
	// scenarios
	task t_locked;
		grd <= 1'b1;
		act <= 1'b1;
		lck <= 1'b1;
		ina <= 1'b1;
		inb <= 1'b1;
		apb(1'b1, GW_REQ_BASE, 32'h0000_0000);
		apb(1'b1, GW_CTRL, 32'h0000_0101);
		cyc(30);
		chk({led_g, led_y, led_r, sa, sb, dgo}, 6'b110111);
		rd(GW_RSP_BASE, 32'h0000_ffff, 32'h0000_0037);
		rd(GW_STAT, 32'h0000_0001, 32'h0000_0000);
		rd(12'h200, 32'hffff_ffff, 32'h0000_0000);
		chk(rerr, 1'b1);
		$display("test locked done");
	endtask : t_locked
	task t_unlocked;
		lck <= 1'b0;
		cyc(30);
		chk({sa, sb, dgo}, 3'b000);
		rd(GW_RSP_BASE, 32'h0000_00ff, 32'h0000_0032);
		rises(1, 8 * BLK, n);
		chk(n > 1, 1'b1);
		lck <= 1'b1;
		near <= 1'b1;
		cyc(10);
		rises(1, 8 * BLK, n);
		chk(n > 1, 1'b1);
		near <= 1'b0;
		cyc(10);
		chk({sa, led_y}, 2'b11);
		$display("test unlocked done");
	endtask : t_unlocked
	task t_link;
		apb(1'b1, GW_REQ_BASE, 32'h0000_0001);
		cyc(20);
		chk(sol, 1'b1);
		apb(1'b1, GW_CTRL, 32'h0000_0100);
		cyc(100);
		chk({sa, sol}, 2'b11);
		apb(1'b1, GW_CTRL, 32'h0000_0101);
		cyc(3);
		rd(GW_RSP_BASE, 32'h0000_4000, 32'h0000_4000);
		apb(1'b1, GW_CTRL, 32'h0000_0201);
		cyc(50);
		rd(GW_STAT, 32'h0000_0003, 32'h0000_0002);
		apb(1'b1, GW_CTRL, 32'h0000_0101);
		cyc(20);
		flt <= 8'h80;
		cyc(10);
		rd(GW_RSP_BASE, 32'h0000_ff00, 32'h0000_8000);
		flt <= 8'h00;
		cyc(5);
		$display("test link done");
	endtask : t_link
	task t_codes;
		for (int i = 0; i < 7; i++) begin
			flt <= 8'h01 << i;
			cyc(3);
			rises(0, (i + 4) * 2 * BLK, n);
			chk(n, (i < 6) ? i + 1 : 0);
			chk({sa, sb, dgo}, (i < 4) ? 3'b110 : 3'b000);
			if (i == 6) chk(led_r, 1'b1);
			rd(GW_RSP_BASE, 32'h0000_3fc0,
				{18'h0, dexp[i][5:0], (i < 4) ? 2'b01 : 2'b10,
				6'h00});
			flt <= 8'h00;
			grd <= 1'b0;
			cyc(5);
			grd <= 1'b1;
			cyc(10);
			chk(sa, 1'b1);
		end
		$display("test codes done");
	endtask : t_codes
	task t_timeout;
		flt <= 8'h08;
		cyc(150);
		chk(sa, 1'b1);
		cyc(70);
		chk(sa, 1'b0);
		flt <= 8'h00;
		cyc(10);
		chk(sa, 1'b0);
		apb(1'b1, GW_REQ_BASE, 32'h0000_0081);
		cyc(20);
		apb(1'b1, GW_REQ_BASE, 32'h0000_0001);
		cyc(20);
		chk(sa, 1'b1);
		flt <= 8'h01;
		cyc(220);
		flt <= 8'h00;
		apb(1'b1, GW_REQ_BASE, 32'h0000_0081);
		cyc(20);
		apb(1'b1, GW_REQ_BASE, 32'h0000_0001);
		cyc(20);
		chk(sa, 1'b0);
		grd <= 1'b0;
		cyc(5);
		grd <= 1'b1;
		cyc(10);
		chk(sa, 1'b1);
		$display("test timeout done");
	endtask : t_timeout
	task t_conv;
		ser <= 1'b0;
		scmd <= 1'b1;
		flt <= 8'h10;
		cyc(10);
		chk({sol, sa}, 2'b10);
		flt <= 8'h00;
		cyc(10);
		chk(sa, 1'b0);
		grd <= 1'b0;
		cyc(5);
		grd <= 1'b1;
		cyc(10);
		chk(sa, 1'b1);
		$display("test conventional done");
	endtask : t_conv
	// ==========================================================
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rst, ser} = 2'b11;
		{psel, pen, pwr, grd, act, near, lck, ina, inb, scmd} = '0;
		paddr = 12'h000;
		pwd = 32'h0000_0000;
		flt = 8'h00;
		cyc(2);
		rst <= 1'b0;
		cyc(1);
		chk({led_g, sa, sb, led_r}, 4'b1000);
		t_locked();
		t_unlocked();
		t_link();
		t_codes();
		t_timeout();
		t_conv();
		test_done();
	end
endmodule : interlock_diagnostic_controller_tb
